// ### inc/vlf_params.svh
// constants for the output-voltage limit and fault-policy register bank
// assumes: included by the timer and core files; no code, definitions only
`ifndef VLF_PARAMS_SVH
`define VLF_PARAMS_SVH

// ----------------------------------------------------------------------------
// command codes of the registers
// ----------------------------------------------------------------------------
`define VLF_OFS_HIGH_WARN   8'h42
`define VLF_OFS_LOW_WARN    8'h43
`define VLF_OFS_LOW_FAULT   8'h44
`define VLF_OFS_LOW_POLICY  8'h45

// ----------------------------------------------------------------------------
// policy field positions
// ----------------------------------------------------------------------------
`define VLF_RESP_HI   7
`define VLF_RESP_LO   6
`define VLF_RETRY_HI  5
`define VLF_RETRY_LO  3
`define VLF_DELAY_HI  2
`define VLF_DELAY_LO  0

// ----------------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------------
`define VLF_RST_THRESHOLD  16'h0000
`define VLF_RST_POLICY     8'h00
`define VLF_RETRY_FOREVER  3'h7
`define VLF_UNIT_CNT_W     8

`endif

// ### inc/vlf_pkg.sv
// types shared by the output-voltage limit and fault-policy block
// assumes: compiled before the core files
`default_nettype none
package vlf_pkg;

  // response codes of the policy field
  typedef enum logic [1:0] {
    RESP_IGNORE    = 2'h0,
    RESP_RIDE      = 2'h1,
    RESP_SHUTDOWN  = 2'h2,
    RESP_HOLD_OFF  = 2'h3
  } vlf_resp_type;

  // fault-handling state machine
  typedef enum logic [2:0] {
    S_RUN,
    S_RIDE,
    S_OFF_WAIT,
    S_RESTART,
    S_HOLD,
    S_LATCH
  } vlf_state_type;

endpackage : vlf_pkg
`default_nettype wire

// ### core/vlf_timer.sv
// delay timer: counts two-to-the-power-of-field time-unit ticks
// assumes: tick is a one-cycle pulse on CLOCK from the time-unit generator
`include "vlf_params.svh"
`default_nettype none
module vlf_timer #(
  parameter int CNT_W = `VLF_UNIT_CNT_W
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             start,
  input  wire logic [2:0]       delay,
  input  wire logic             tick,
  output logic                  done
);
  import vlf_pkg::*;

  // ----------------------------------------------------------------------------
  // unit count decode
  // ----------------------------------------------------------------------------
  function automatic logic [CNT_W:0] dly_units(input logic [2:0] code);
    dly_units = (CNT_W+1)'(1) << code;
  endfunction : dly_units

  logic [CNT_W:0] cnt_r;
  logic [CNT_W:0] cnt_nxt;
  logic           busy_r;
  logic           busy_nxt;
  logic           done_nxt;
  wire            last_tick = busy_r && tick && (cnt_r == dly_units(delay) - 1'b1);

  // ----------------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------------
  assign cnt_nxt  = start ? '0 : (busy_r && tick) ? cnt_r + 1'b1 : cnt_r;
  assign busy_nxt = start | (busy_r & ~last_tick);
  assign done_nxt = ~start & last_tick;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done   <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
      done   <= done_nxt;
    end
  end

endmodule : vlf_timer
`default_nettype wire

// ### core/vlf_core.sv
// output-voltage warning/fault thresholds and under-voltage fault policy
// assumes: command port driven by the management-bus front end on CLOCK;
// VOUT_MEAS, OPER_ON and UNIT_TICK come from logic on CLOCK; CTRL_PIN is a pin
`include "vlf_params.svh"
`default_nettype none
module vlf_core #(
  parameter int THR_W = 16
) (
  input  wire logic             CLOCK,
  input  wire logic             RST_B,
  input  wire logic [7:0]       REG_CMD,
  input  wire logic             REG_WR,
  input  wire logic             REG_RD,
  input  wire logic [THR_W-1:0] REG_WDATA,
  output logic [THR_W-1:0]      REG_RDATA,
  output logic                  REG_ACK,
  output logic                  REG_NAK,
  input  wire logic [THR_W-1:0] VOUT_MEAS,
  input  wire logic             CTRL_PIN,
  input  wire logic             OPER_ON,
  input  wire logic             CLEAR_FAULTS,
  input  wire logic             CLEAR_UV_BIT,
  input  wire logic             OTHER_FAULT,
  input  wire logic             UNIT_TICK,
  output logic                  OUTPUT_EN,
  output logic                  OV_WARN,
  output logic                  UV_WARN,
  output logic                  UV_FAULT,
  output logic                  UV_FLAG,
  output logic                  UV_LATCHED
);
  import vlf_pkg::*;

  // ----------------------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------------------
  localparam logic [7:0] THR_OFS [0:2] = '{`VLF_OFS_HIGH_WARN, `VLF_OFS_LOW_WARN,
                                           `VLF_OFS_LOW_FAULT};

  logic [THR_W-1:0] thr_r [0:2];
  logic [7:0]       policy_r;
  logic [2:0]       thr_hit;
  wire              pol_hit = (REG_CMD == `VLF_OFS_LOW_POLICY);
  wire              mapped  = |thr_hit | pol_hit;

  // one 16-bit threshold per code, shared write path
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_thr
      assign thr_hit[gi] = (REG_CMD == THR_OFS[gi]);
      always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
          thr_r[gi] <= `VLF_RST_THRESHOLD;
        end else if (REG_WR && thr_hit[gi]) begin
          thr_r[gi] <= REG_WDATA;
        end
      end
    end
  endgenerate

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      policy_r <= `VLF_RST_POLICY;
    end else if (REG_WR && pol_hit) begin
      policy_r <= REG_WDATA[7:0];
    end
  end

  wire [THR_W-1:0] rd_mux = thr_hit[0] ? thr_r[0] :
                            thr_hit[1] ? thr_r[1] :
                            thr_hit[2] ? thr_r[2] :
                            pol_hit    ? {{(THR_W-8){1'b0}}, policy_r} : '0;

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      REG_RDATA <= '0;
      REG_ACK   <= 1'b0;
      REG_NAK   <= 1'b0;
    end else begin
      REG_RDATA <= REG_RD ? rd_mux : REG_RDATA;
      REG_ACK   <= (REG_RD | REG_WR) & mapped;
      REG_NAK   <= (REG_RD | REG_WR) & ~mapped;
    end
  end

  // ----------------------------------------------------------------------------
  // policy fields
  // ----------------------------------------------------------------------------
  wire vlf_resp_type resp  = vlf_resp_type'(policy_r[`VLF_RESP_HI:`VLF_RESP_LO]);
  wire [2:0]         retry = policy_r[`VLF_RETRY_HI:`VLF_RETRY_LO];
  wire [2:0]         delay = policy_r[`VLF_DELAY_HI:`VLF_DELAY_LO];

  // ----------------------------------------------------------------------------
  // control pin synchroniser and on command
  // ----------------------------------------------------------------------------
  logic ctrl_s1_r;
  logic ctrl_s2_r;
  logic ctrl_s3_r;
  logic ctrl_on_r;
  logic on_prev_r;

  wire on_cmd    = ctrl_on_r & OPER_ON;
  wire off_edge  = on_prev_r & ~on_cmd;
  wire clear_any = CLEAR_FAULTS | CLEAR_UV_BIT | off_edge;

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      ctrl_s1_r <= 1'b0;
      ctrl_s2_r <= 1'b0;
      ctrl_s3_r <= 1'b0;
      ctrl_on_r <= 1'b0;
      on_prev_r <= 1'b0;
    end else begin
      ctrl_s1_r <= CTRL_PIN;
      ctrl_s2_r <= ctrl_s1_r;
      ctrl_s3_r <= ctrl_s2_r;
      ctrl_on_r <= (ctrl_s2_r == ctrl_s3_r) ? ctrl_s3_r : ctrl_on_r;
      on_prev_r <= on_cmd;
    end
  end

  // ----------------------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      OV_WARN  <= 1'b0;
      UV_WARN  <= 1'b0;
      UV_FAULT <= 1'b0;
    end else begin
      OV_WARN  <= VOUT_MEAS > thr_r[0];
      UV_WARN  <= VOUT_MEAS < thr_r[1];
      UV_FAULT <= VOUT_MEAS < thr_r[2];
    end
  end

  // ----------------------------------------------------------------------------
  // delay timer
  // ----------------------------------------------------------------------------
  logic tmr_start;
  logic tmr_done;

  vlf_timer u_timer (
    .clk   (CLOCK),
    .rst_b (RST_B),
    .start (tmr_start),
    .delay (delay),
    .tick  (UNIT_TICK),
    .done  (tmr_done)
  );

  // ----------------------------------------------------------------------------
  // fault policy state machine
  // ----------------------------------------------------------------------------
  vlf_state_type state_r;
  vlf_state_type state_nxt;
  logic [2:0]    tries_r;
  logic [2:0]    tries_nxt;
  logic          flag_r;

  wire more_tries = (retry == `VLF_RETRY_FOREVER) || (tries_r < retry);

  always_comb begin
    state_nxt = state_r;
    tries_nxt = tries_r;
    tmr_start = 1'b0;
    case (state_r)
      S_RUN: begin
        if (on_cmd && UV_FAULT) begin
          case (resp)
            RESP_RIDE: begin
              state_nxt = S_RIDE;
              tmr_start = 1'b1;
            end
            RESP_SHUTDOWN: begin
              tries_nxt = '0;
              tmr_start = (retry != 3'h0);
              state_nxt = (retry == 3'h0) ? S_LATCH : S_OFF_WAIT;
            end
            RESP_HOLD_OFF: state_nxt = S_HOLD;
            default:       state_nxt = S_RUN;
          endcase
        end
      end
      S_RIDE: begin
        if (!UV_FAULT) begin
          state_nxt = S_RUN;
        end else if (tmr_done) begin
          tries_nxt = '0;
          tmr_start = (retry != 3'h0);
          state_nxt = (retry == 3'h0) ? S_LATCH : S_OFF_WAIT;
        end
      end
      S_OFF_WAIT: begin
        if (OTHER_FAULT) begin
          state_nxt = S_LATCH;
        end else if (tmr_done) begin
          state_nxt = S_RESTART;
          tries_nxt = (tries_r == 3'h7) ? tries_r : tries_r + 3'h1;
          tmr_start = 1'b1;
        end
      end
      S_RESTART: begin
        if (OTHER_FAULT) begin
          state_nxt = S_LATCH;
        end else if (tmr_done) begin
          if (!UV_FAULT) begin
            state_nxt = S_RUN;
          end else if (more_tries) begin
            state_nxt = S_OFF_WAIT;
            tmr_start = 1'b1;
          end else begin
            state_nxt = S_LATCH;
          end
        end
      end
      S_HOLD: begin
        if (!UV_FAULT) begin
          state_nxt = S_RUN;
        end
      end
      S_LATCH: begin
        if (CLEAR_FAULTS || CLEAR_UV_BIT) begin
          state_nxt = S_RUN;
        end
      end
      default: state_nxt = S_RUN;
    endcase
    if (!on_cmd) begin
      state_nxt = S_RUN;
      tmr_start = 1'b0;
    end
  end

  wire out_on_nxt = on_cmd && (state_nxt == S_RUN || state_nxt == S_RIDE ||
                               state_nxt == S_RESTART);

  // sticky fault flag: a new detection wins over a clear in the same cycle
  wire flag_nxt = (on_cmd & UV_FAULT) | (flag_r & ~clear_any);

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      state_r   <= S_RUN;
      tries_r   <= '0;
      flag_r    <= 1'b0;
      OUTPUT_EN <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      tries_r   <= tries_nxt;
      flag_r    <= flag_nxt;
      OUTPUT_EN <= out_on_nxt;
    end
  end

  assign UV_FLAG    = flag_r;
  assign UV_LATCHED = (state_r == S_LATCH);

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  chk_thr_write: assert property (@(posedge CLOCK) disable iff (!RST_B)
    REG_WR && REG_CMD == `VLF_OFS_LOW_FAULT |=> thr_r[2] == $past(REG_WDATA))
    else $error("fault threshold write lost");

  chk_high_warn: assert property (@(posedge CLOCK) disable iff (!RST_B)
    VOUT_MEAS > thr_r[0] && !(REG_WR && thr_hit[0]) |=> OV_WARN)
    else $error("high warning missed");

  chk_low_fault: assert property (@(posedge CLOCK) disable iff (!RST_B)
    VOUT_MEAS >= thr_r[2] && !(REG_WR && thr_hit[2]) |=> !UV_FAULT)
    else $error("false low fault");

  chk_ignore_runs: assert property (@(posedge CLOCK) disable iff (!RST_B)
    state_r == S_RUN && resp == RESP_IGNORE && !(REG_WR && pol_hit) |=> state_r == S_RUN)
    else $error("ignore response left run");

  chk_ride_on: assert property (@(posedge CLOCK) disable iff (!RST_B)
    state_r == S_RIDE |-> OUTPUT_EN)
    else $error("output off while riding through");

  chk_shut_now: assert property (@(posedge CLOCK) disable iff (!RST_B)
    state_r == S_RUN && on_cmd && UV_FAULT && resp == RESP_SHUTDOWN |=> !OUTPUT_EN)
    else $error("shutdown response kept output on");

  chk_hold_cycle: assert property (@(posedge CLOCK) disable iff (!RST_B)
    state_r == S_HOLD && on_cmd |=> (OUTPUT_EN == !$past(UV_FAULT)))
    else $error("hold-off response wrong");

  chk_latch_stays: assert property (@(posedge CLOCK) disable iff (!RST_B)
    state_r == S_LATCH && on_cmd && !CLEAR_FAULTS && !CLEAR_UV_BIT |=> UV_LATCHED && !OUTPUT_EN)
    else $error("latched output came back");

  chk_latch_clear: assert property (@(posedge CLOCK) disable iff (!RST_B)
    state_r == S_LATCH && (CLEAR_FAULTS || !on_cmd) |=> !UV_LATCHED)
    else $error("latch not cleared");

  chk_retry_forever: assert property (@(posedge CLOCK) disable iff (!RST_B)
    state_r == S_RESTART && tmr_done && UV_FAULT && on_cmd && !OTHER_FAULT
      && retry == `VLF_RETRY_FOREVER |=> state_r == S_OFF_WAIT)
    else $error("continuous retry stopped");

  chk_retry_limit: assert property (@(posedge CLOCK) disable iff (!RST_B)
    state_r == S_RESTART && tmr_done && UV_FAULT && on_cmd && retry != `VLF_RETRY_FOREVER
      && tries_r >= retry |=> UV_LATCHED)
    else $error("retry count exceeded");

endmodule : vlf_core
`default_nettype wire

// ### verif/vlf_host.sv
// host model: drives the register port one access at a time
// assumes: clk from the bench; expected answers go to exp_q for the bench monitor
`default_nettype none
module vlf_host (
  input  wire logic        clk,
  output logic [7:0]       cmd,
  output logic             wr,
  output logic             rd,
  output logic [15:0]      wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // entry: read flag, nak flag, read data
  logic [17:0] exp_q[$];
  initial begin
    cmd = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 16'h0000;
  end
  // ----------------------------------------------------------------------------
  // one access: strobe for one cycle, taken at the following edge
  // ----------------------------------------------------------------------------
  task acc(input logic isrd, input logic [7:0] c, input logic [15:0] d,
           input logic [15:0] e);
    logic nak;
    nak = !(c inside {[8'h42:8'h45]});
    @(posedge clk);
    cmd <= c;
    wdata <= d;
    rd <= isrd;
    wr <= !isrd;
    exp_q.push_back({isrd, nak, e});
    @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : acc
endmodule : vlf_host
`default_nettype wire

// ### verif/vout_limit_fault_response_test.sv
// bench for the limit registers and under-voltage fault policy
// assumes: vlf_core and vlf_host compiled; unit tick made here every 4 cycles
`default_nettype none
module vout_limit_fault_response_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  reg_cmd;
  logic        reg_wr, reg_rd;
  logic [15:0] reg_wdata, reg_rdata;
  logic        reg_ack, reg_nak;
  logic [15:0] vout = 16'h5800;
  logic        ctrl_pin = 1'b1;
  logic        oper_on = 1'b1;
  logic        clear_faults = 1'b0;
  logic        clear_uv_bit = 1'b0;
  logic        other_fault = 1'b0;
  logic        unit_tick = 1'b0;
  logic [1:0]  tick_cnt = 2'h0;
  logic        output_en, ov_warn, uv_warn, uv_fault, uv_flag, uv_latched;
  int          num_errors = 0;
  int          total_checks = 0;
  logic [31:0] seed = 32'h2068c965;
  logic [17:0] e;
  int          rises, ff;
  logic        lat;
  logic [15:0] v[6] = '{16'h6001, 16'h6000, 16'h5000, 16'h4fff, 16'h4000, 16'h3fff};
  logic [2:0]  w[6] = '{3'b100, 3'b000, 3'b000, 3'b010, 3'b010, 3'b011};
  always #20 clock = ~clock;
  always @(posedge clock) begin
    tick_cnt <= tick_cnt + 2'h1;
    unit_tick <= &tick_cnt;
  end
  vlf_host u_host (.clk(clock), .cmd(reg_cmd), .wr(reg_wr), .rd(reg_rd), .wdata(reg_wdata));
  vlf_core u_dut (.CLOCK(clock), .RST_B(rst_b), .REG_CMD(reg_cmd), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_ACK(reg_ack),
    .REG_NAK(reg_nak), .VOUT_MEAS(vout), .CTRL_PIN(ctrl_pin), .OPER_ON(oper_on),
    .CLEAR_FAULTS(clear_faults), .CLEAR_UV_BIT(clear_uv_bit), .OTHER_FAULT(other_fault),
    .UNIT_TICK(unit_tick), .OUTPUT_EN(output_en), .OV_WARN(ov_warn), .UV_WARN(uv_warn),
    .UV_FAULT(uv_fault), .UV_FLAG(uv_flag), .UV_LATCHED(uv_latched));
  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wrap_up;
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // monitor: oldest note against each answer
  always @(negedge clock) begin
    if (reg_ack === 1'b1 || reg_nak === 1'b1) begin
      if (u_host.exp_q.size() == 0) begin
        chk(16'h0001, 16'h0000);
      end else begin
        e = u_host.exp_q.pop_front();
        chk({reg_ack, reg_nak}, {!e[16], e[16]});
        if (e[17]) chk(reg_rdata, e[15:0]);
      end
    end
  end
  task pulse(input int which);
    @(posedge clock);
    if (which == 0) clear_faults <= 1'b1;
    else clear_uv_bit <= 1'b1;
    @(posedge clock);
    clear_faults <= 1'b0;
    clear_uv_bit <= 1'b0;
  endtask : pulse
  // fault with policy pol, watch the output for up to win cycles
  task trial(input logic [7:0] pol, input logic of, input int win);
    logic prev;
    u_host.acc(1'b0, 8'h45, {8'h00, pol}, 16'h0000);
    pulse(0);
    repeat (4) @(posedge clock);
    rises = 0;
    ff = -1;
    lat = 1'b0;
    prev = 1'b1;
    vout <= 16'h3000;
    other_fault <= of;
    for (int n = 0; n < win && !lat; n++) begin
      @(negedge clock);
      if (output_en === 1'b1 && !prev) rises++;
      if (output_en !== 1'b1 && prev && ff < 0) ff = n;
      prev = (output_en === 1'b1);
      lat = (uv_latched === 1'b1);
    end
    chk(uv_flag, 1'b1);
    vout <= 16'h5800;
    other_fault <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : trial
  // clear by one of four ways, then expect the output running again
  task clr(input int how);
    if (how < 2) pulse(how);
    @(posedge clock);
    if (how == 2) oper_on <= 1'b0;
    if (how == 3) ctrl_pin <= 1'b0;
    repeat (8) @(posedge clock);
    oper_on <= 1'b1;
    ctrl_pin <= 1'b1;
    repeat (12) @(posedge clock);
    chk({uv_latched, uv_flag, output_en}, 3'b001);
  endtask : clr
  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) u_host.acc(1'b1, 8'h42 + i[7:0], 16'h0, 16'h0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      u_host.acc(1'b0, 8'h42 + i[7:0], seed[15:0], 16'h0);
      u_host.acc(1'b1, 8'h42 + i[7:0], 16'h0, (i == 3) ? {8'h00, seed[7:0]} : seed[15:0]);
    end
    u_host.acc(1'b0, 8'h41, 16'hffff, 16'h0);
    u_host.acc(1'b1, 8'h41, 16'h0, 16'h0);
    u_host.acc(1'b0, 8'h45, 16'h0000, 16'h0);
    u_host.acc(1'b0, 8'h42, 16'h6000, 16'h0);
    u_host.acc(1'b0, 8'h43, 16'h5000, 16'h0);
    u_host.acc(1'b0, 8'h44, 16'h4000, 16'h0);
    for (int i = 0; i < 6; i++) begin
      vout <= v[i];
      repeat (3) @(posedge clock);
      chk({ov_warn, uv_warn, uv_fault}, w[i]);
    end
    vout <= 16'h5800;
    clr(0);
    trial(8'h00, 1'b0, 100);
    chk({rises[3:0], ff[3:0], 3'b000, lat}, {4'h0, 4'hf, 4'h0});
    trial(8'hc0, 1'b0, 60);
    chk({rises[3:0], 3'b000, lat, 7'h00, ff < 4}, 16'h0001);
    chk(output_en, 1'b1);
    clr(1);
    for (int r = 0; r < 7; r++) begin
      trial({2'b10, r[2:0], 3'd0}, 1'b0, 400);
      chk({rises[7:0], 7'h00, lat}, {r[7:0], 8'h01});
      clr(r % 4);
    end
    trial({2'b10, 3'd7, 3'd0}, 1'b0, 300);
    chk({rises > 6, lat}, 2'b10);
    clr(2);
    trial({2'b10, 3'd7, 3'd0}, 1'b1, 300);
    chk(lat, 1'b1);
    clr(3);
    for (int d = 0; d < 8; d++) begin
      trial({2'b01, 3'd0, d[2:0]}, 1'b0, 700);
      chk({ff >= 4 * ((1 << d) - 1), ff <= 4 * (1 << d) + 6, lat}, 3'b111);
      clr(d % 4);
    end
    repeat (4) @(posedge clock);
    chk(u_host.exp_q.size(), 16'h0000);
    wrap_up();
  end
  initial begin
    #1000000;
    num_errors++;
    wrap_up();
  end
endmodule : vout_limit_fault_response_test
`default_nettype wire
